// ===== hw/drs_pkg.sv
// Package: constants and carrier types for the refresh sequencer
package drs_pkg;

    localparam logic [3:0] DRS_CNT_PRESET = 4'hD;
    localparam logic [3:0] DRS_CNT_WIN    = 4'hE;
    localparam logic [3:0] DRS_CNT_CLEAR  = 4'h0;
    localparam logic [6:0] DRS_ROW_RESET  = 7'h00;
    localparam logic [3:0] DRS_RAS_ALL    = 4'hF;
    localparam int         DRS_ROW_BITS   = 7;
    localparam int         DRS_CLK_NS     = 100;
    localparam int         DRS_DELAY_NS   = 20;
    localparam int         DRS_DELAY_CYC  =
        (DRS_DELAY_NS + DRS_CLK_NS - 1) / DRS_CLK_NS;

    typedef struct packed {
        logic                    refresh_grant;
        logic [DRS_ROW_BITS-1:0] row;
    } drs_row_req_t;

    typedef struct packed {
        logic       ras_n;
        logic [3:0] ras_all_n;
        logic       cas_inhibit;
        logic       latch_hold;
        logic       rdy_pull_n;
    } drs_strobe_t;

    typedef enum logic [1:0] {
        DRS_IDLE   = 2'b00,
        DRS_COUNT  = 2'b01,
        DRS_LOADED = 2'b10
    } drs_mode_t;

endpackage

// ===== hw/drs_row_counter.sv
// Module: 7-bit refresh row address counter
`timescale 1ns/1ps
`default_nettype none
module drs_row_counter
    import drs_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         refresh_grant_i,
    output var drs_row_req_t  row_req_o
);
    typedef struct packed {
        logic                    grant_d;
        logic [DRS_ROW_BITS-1:0] row;
    } drs_rc_state_t;

    drs_rc_state_t st;
    drs_rc_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.grant_d = refresh_grant_i;
        if (st.grant_d && !refresh_grant_i)
        begin
            next_st.row = st.row + 7'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '{grant_d: 1'b0, row: DRS_ROW_RESET};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign row_req_o = '{refresh_grant: refresh_grant_i, row: st.row};

    a_row_step: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(refresh_grant_i) |=> st.row == $past(st.row) + 7'h01)
        else $error("row did not step");
endmodule
`default_nettype wire

// ===== hw/drs_sequencer.sv
// Module: refresh sequencer top
// Behaviour
// - Reset, hold acknowledge or wait starts self-timed refresh requests.
// - Counter advances from zero, or from preset 13; window active at counts 14 and 15.
// - Granted refresh drives all four row strobes after delayed enable.
// - Keep 7-bit row counter, drive it on address outputs during grant.
// - Row counter increments when grant ends, walking 128 rows.
// - Window active and board selected pulls ready low.
// - After 14 and 15 counter wraps to zero, runs 14 counts idle.
// - First refresh 14 clocks after condition from idle; two-clock bursts every 16.
// - Self-timed pulse retimed half a clock later than the counter.
// - Memory request with window inactive stops counter, presets 13.
// - Jumper fitted: processor refresh asserts grant with row address.
// - Grant enables row strobe gating and suppresses column strobes.
// - Processor refresh: memory request pulses delay, firing row strobes.
// - Grant asserts output latch enable to hold data.
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer
    import drs_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         bus_reset_i,
    input  wire logic         hold_ack_i,
    input  wire logic         bus_wait_i,
    input  wire logic         bus_mem_request_hi_i,
    input  wire logic         cpu_refresh_n_i,
    input  wire logic         board_selected_i,
    input  wire logic         cpu_refresh_jumper_i,
    input  wire logic         ready_hold_jumper_i,
    input  wire logic         row_strobe_jumper_i,
    output logic              onboard_refresh_window_o,
    output logic              refresh_grant_o,
    output logic [6:0]        mem_addr_o,
    output logic [3:0]        row_strobe_n_o,
    output logic              col_strobe_inhibit_o,
    output logic              latch_hold_o,
    output logic              rdy_o,
    output logic              rdy_oe_n_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0] count;
        logic       delay;
        logic       cpu_mem_request_n_d;
        logic [3:0] ras_n;
        logic       grant;
    } drs_state_t;

    // Half-clock retime state
    typedef struct packed {
        logic pulse;
        logic win_lo;
    } drs_lo_state_t;

    drs_state_t    st;
    drs_state_t    next_st;
    drs_lo_state_t lo_st;
    drs_lo_state_t next_lo;
    drs_row_req_t  row_req;
    logic          start_refresh;
    logic          window;
    logic          cpu_grant;

    function automatic logic is_window(input logic [3:0] c);
        is_window = (c >= DRS_CNT_WIN);
    endfunction

    assign start_refresh = bus_reset_i | hold_ack_i | bus_wait_i;
    assign window = is_window(st.count);
    assign cpu_grant = cpu_refresh_jumper_i & ~cpu_refresh_n_i;

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.cpu_mem_request_n_d = bus_mem_request_hi_i;
        if (bus_mem_request_hi_i && !window)
        begin
            next_st.count = DRS_CNT_PRESET;
        end
        else if (!start_refresh && !window)
        begin
            next_st.count = DRS_CNT_CLEAR;
        end
        else
        begin
            next_st.count = st.count + 4'h1;
        end
        next_st.grant = is_window(next_st.count) | cpu_grant;
        next_st.delay = lo_st.pulse | (cpu_grant & bus_mem_request_hi_i
            & ~st.cpu_mem_request_n_d & ~window);
        next_st.ras_n = DRS_RAS_ALL;
        if (st.grant && st.delay && row_strobe_jumper_i)
        begin
            next_st.ras_n = ~DRS_RAS_ALL;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '{count:  DRS_CNT_CLEAR,
                    delay:  1'b0,
                    cpu_mem_request_n_d: 1'b0,
                    ras_n:  DRS_RAS_ALL,
                    grant:  1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        next_lo.win_lo = window;
        next_lo.pulse  = window & ~lo_st.win_lo;
    end

    always_ff @(negedge clk_i)
    begin
        if (rst_i)
        begin
            lo_st <= '{pulse: 1'b0, win_lo: 1'b0};
        end
        else
        begin
            lo_st <= next_lo;
        end
    end

    drs_row_counter drs_row_counter_i
    (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .refresh_grant_i (refresh_grant_o),
        .row_req_o       (row_req)
    );

    // ==========================================================
    // Outputs
    assign onboard_refresh_window_o = window;
    assign refresh_grant_o = window | cpu_grant;
    assign mem_addr_o = row_req.row;
    assign row_strobe_n_o = st.ras_n;
    assign col_strobe_inhibit_o = refresh_grant_o;
    assign latch_hold_o = refresh_grant_o;
    assign rdy_o = 1'b0;
    assign rdy_oe_n_o = ~(window & board_selected_i & ready_hold_jumper_i);

    // ==========================================================
    // Checks
    sequence s_win_start;
        $rose(window);
    endsequence

    sequence s_burst;
        window [*2] ##1 !window;
    endsequence

    a_cond_start: assert property (@(posedge clk_i) disable iff (rst_i)
        start_refresh && !bus_mem_request_hi_i
        && st.count == DRS_CNT_PRESET |=> window)
        else $error("no refresh after condition");

    a_win_count: assert property (@(posedge clk_i) disable iff (rst_i)
        window == (st.count == 4'hE || st.count == 4'hF))
        else $error("window decode wrong");

    a_burst_len: assert property (@(posedge clk_i) disable iff (rst_i)
        s_win_start |-> s_burst)
        else $error("burst not two clocks");

    a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        st.count == 4'hF |=> st.count == 4'h0)
        else $error("counter did not wrap");

    a_preset_13: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_mem_request_hi_i && !window |=> st.count == 4'hD)
        else $error("counter not preset");

    a_idle_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        !start_refresh && !window && !bus_mem_request_hi_i
        |=> st.count == 4'h0)
        else $error("counter not cleared");

    a_rdy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        window && board_selected_i && ready_hold_jumper_i |-> !rdy_oe_n_o)
        else $error("ready not pulled");

    a_col_block: assert property (@(posedge clk_i) disable iff (rst_i)
        refresh_grant_o |-> col_strobe_inhibit_o && latch_hold_o)
        else $error("column strobe not blocked");

    a_ras_fire: assert property (@(posedge clk_i) disable iff (rst_i)
        st.grant && st.delay && row_strobe_jumper_i
        |=> row_strobe_n_o == 4'h0)
        else $error("row strobes not fired");
endmodule
`default_nettype wire

// ===== test/drs_host_model.sv
// Host processor model driving bus conditions and requests
`timescale 1ns/1ps
`default_nettype none
module drs_host_model
(
    input  wire logic clk_i,
    input  wire logic rdy_oe_n_i,
    output logic      bus_reset_o,
    output logic      hold_ack_o,
    output logic      bus_wait_o,
    output logic      mem_request_hi_o,
    output logic      cpu_refresh_n_o
);
    initial
    begin
        {bus_reset_o, hold_ack_o, bus_wait_o} = 3'h0;
        mem_request_hi_o = 1'h0;
        cpu_refresh_n_o = 1'h1;
    end
    task automatic set_cond(input logic r, input logic h, input logic w);
        @(posedge clk_i);
        #10;
        {bus_reset_o, hold_ack_o, bus_wait_o} = {r, h, w};
    endtask
    task automatic mem_pulse();
        @(posedge clk_i);
        #10;
        while (rdy_oe_n_i === 1'h0)
        begin
            @(posedge clk_i);
            #10;
        end
        mem_request_hi_o = 1'h1;
        @(posedge clk_i);
        #10;
        mem_request_hi_o = 1'h0;
    endtask
    task automatic cpu_refresh(input logic on);
        @(posedge clk_i);
        #10;
        mem_request_hi_o = on;
        cpu_refresh_n_o = ~on;
    endtask
endmodule
`default_nettype wire

// ===== test/dram_refresh_sequencer_tb.sv
// Testbench for the refresh sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
 error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dram_refresh_sequencer_tb;
    import drs_pkg::*;
    logic       clk_i = 1'h0;
    logic       rst_i = 1'h1;
    logic       sel = 1'h1;
    logic       jmp = 1'h1;
    logic       rdy_jmp = 1'h1;
    logic       ras_jmp = 1'h1;
    logic       br, ha, bw, mrq, rf_n, win, gnt, cinh, lth, rdy, oe_n;
    logic [6:0] addr;
    logic [3:0] ras_n;
    logic [6:0] exp_row = DRS_ROW_RESET;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         cyc = 0;
    always #50 clk_i = ~clk_i;
    drs_host_model drs_host_model_i (.clk_i(clk_i), .rdy_oe_n_i(oe_n),
        .bus_reset_o(br), .hold_ack_o(ha), .bus_wait_o(bw),
        .mem_request_hi_o(mrq), .cpu_refresh_n_o(rf_n));
    drs_sequencer drs_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
        .bus_reset_i(br), .hold_ack_i(ha), .bus_wait_i(bw),
        .bus_mem_request_hi_i(mrq), .cpu_refresh_n_i(rf_n),
        .board_selected_i(sel), .cpu_refresh_jumper_i(jmp),
        .ready_hold_jumper_i(rdy_jmp), .row_strobe_jumper_i(ras_jmp),
        .onboard_refresh_window_o(win), .refresh_grant_o(gnt),
        .mem_addr_o(addr), .row_strobe_n_o(ras_n),
        .col_strobe_inhibit_o(cinh), .latch_hold_o(lth),
        .rdy_o(rdy), .rdy_oe_n_o(oe_n));
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            error_cnt++;
            close_out();
        end
    end
    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            #10;
        end
    endtask
    task automatic to_win(output int n);
        n = 0;
        while (win !== 1'h1 && n < 40)
        begin
            tk(1);
            n++;
        end
    endtask
    task automatic t_idle();
        tk(3);
        repeat (20)
        begin
            `CHK("idle", 2'h1, {win, oe_n})
            tk(1);
        end
    endtask
    task automatic t_burst(input logic s, input logic j,
                           input logic [2:0] c);
        int   n, hi, lo;
        logic ras;
        sel = s;
        rdy_jmp = j;
        drs_host_model_i.set_cond(c[2], c[1], c[0]);
        to_win(n);
        `CHK("first window", 1'h1, n <= 16)
        repeat (2)
        begin
            hi = 0;
            lo = 0;
            ras = 1'h0;
            `CHK("row addr", exp_row, addr)
            `CHK("grant set", 3'h7, {gnt, cinh, lth})
            `CHK("rdy drive", {s & j, 1'h0}, {~oe_n, rdy})
            while (win === 1'h1 && hi < 20)
            begin
                tk(1);
                hi++;
                ras |= ras_n === 4'h0;
            end
            while (win === 1'h0 && lo < 40)
            begin
                tk(1);
                lo++;
                ras |= ras_n === 4'h0;
            end
            `CHK("window len", 2, hi)
            `CHK("idle len", 14, lo)
            `CHK("row strobes", 1'h1, ras)
            exp_row++;
        end
        exp_row++;
        drs_host_model_i.set_cond(1'h0, 1'h0, 1'h0);
        sel = 1'h1;
        rdy_jmp = 1'h1;
    endtask
    task automatic t_preset();
        int n;
        drs_host_model_i.set_cond(1'h0, 1'h0, 1'h1);
        tk(4);
        drs_host_model_i.mem_pulse();
        to_win(n);
        `CHK("preset window", 1'h1, n <= 2)
        exp_row++;
        drs_host_model_i.set_cond(1'h0, 1'h0, 1'h0);
        tk(4);
    endtask
    task automatic t_cpu();
        logic ras;
        ras = 1'h0;
        drs_host_model_i.cpu_refresh(1'h1);
        #1;
        `CHK("cpu grant", 3'h7, {gnt, cinh, lth})
        `CHK("cpu row", exp_row, addr)
        repeat (3)
        begin
            tk(1);
            ras |= ras_n === 4'h0;
        end
        `CHK("cpu strobes", 1'h1, ras)
        drs_host_model_i.cpu_refresh(1'h0);
        tk(2);
        exp_row++;
        ras_jmp = 1'h0;
        ras = 1'h0;
        drs_host_model_i.cpu_refresh(1'h1);
        repeat (3)
        begin
            tk(1);
            ras |= ras_n === 4'h0;
        end
        `CHK("strobes off", 1'h0, ras)
        drs_host_model_i.cpu_refresh(1'h0);
        tk(2);
        exp_row++;
        ras_jmp = 1'h1;
        jmp = 1'h0;
        drs_host_model_i.cpu_refresh(1'h1);
        #1;
        `CHK("no jumper", 1'h0, gnt)
        drs_host_model_i.cpu_refresh(1'h0);
        jmp = 1'h1;
        drs_host_model_i.cpu_refresh(1'h1);
        `CHK("row step", exp_row, addr)
        drs_host_model_i.cpu_refresh(1'h0);
        tk(2);
    endtask
    initial
    begin
        tk(5);
        rst_i = 1'h0;
        t_idle();
        t_burst(1'h1, 1'h1, 3'h4);
        t_idle();
        t_burst(1'h0, 1'h1, 3'h2);
        t_idle();
        t_burst(1'h1, 1'h0, 3'h1);
        t_idle();
        t_preset();
        t_cpu();
        close_out();
    end
endmodule
`default_nettype wire
